// ---- sgd_pkg.sv ----
// Package for the graphics DRAM command interface: widths, command codes,
// mode register field positions, reset values and timing counts.
// Assumes a single 20 MHz core clock and no register bus.
package sgd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 10;
  localparam int ROW_W   = 10;
  localparam int COL_W   = 8;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int BANKS   = 2;
  localparam int OPC_W   = 11;

  // Address bit that requests auto precharge or a close of both banks
  localparam int AP_BIT  = 9;

  // ----------------------------------------------------------------
  // Mode register fields (op-code bit 10 is bank_select_in)
  // ----------------------------------------------------------------
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BL_MSB  = 2;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int MR_CL_MSB  = 6;
  localparam int MR_WB_BIT  = 9;
  localparam logic [10:0] MR_RESET = 11'h021;

  // Burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Special mode register: bit 5 loads mask, bit 6 loads colour
  localparam int SMR_MASK_BIT  = 5;
  localparam int SMR_COLOR_BIT = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int TRP_NS        = 100;
  localparam int TRP_CYC       = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int MASK_RD_LAT   = 2;
  localparam int REFRESH_ROWS  = 2048;
  localparam int REFRESH_MS    = 32;

  // ----------------------------------------------------------------
  // Decoded commands (bits: row, column, write strobes, active low)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS   = 3'h0,
    CMD_REF   = 3'h1,
    CMD_PRE   = 3'h2,
    CMD_ACT   = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ  = 3'h5,
    CMD_STOP  = 3'h6,
    CMD_NOP   = 3'h7
  } sgd_cmd_t;

  // Bank state
  typedef enum logic [1:0] {
    BANK_IDLE   = 2'h0,
    BANK_ACTIVE = 2'h1,
    BANK_PRECH  = 2'h2
  } sgd_bank_t;

  // Power state
  typedef enum logic [1:0] {
    PWR_RUN     = 2'h0,
    PWR_DOWN    = 2'h1,
    PWR_SELFREF = 2'h2
  } sgd_pwr_t;

endpackage

// ---- sgd_burst_addr.sv ----
// Burst column sequencer: produces the column for each beat of a burst.
// Assumes the caller holds step low while the internal clock is suspended.
`timescale 1ns/1ns
module sgd_burst_addr (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  // Control
  input  wire logic                     load,
  input  wire logic                     step,
  input  wire logic [sgd_pkg::COL_W-1:0] startCol,
  input  wire logic                     interleave,
  // Column
  output logic      [sgd_pkg::COL_W-1:0] col
);

  logic [sgd_pkg::COL_W-1:0] baseQ;
  logic [sgd_pkg::COL_W-1:0] cntQ;

  // Start column and beat count; count only moves on an enabled edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      baseQ <= 8'h00;
      cntQ  <= 8'h00;
    end else if (load) begin
      baseQ <= startCol;
      cntQ  <= 8'h00;
    end else if (step) begin
      cntQ  <= cntQ + 8'h01;
    end
  end

  // Interleaved order xors the count, linear adds it with wrap
  always_comb begin
    if (interleave) begin
      col = baseQ ^ cntQ;
    end else begin
      col = baseQ + cntQ;
    end
  end

endmodule

// ---- sgd_cmd_interface.sv ----
// Command and control core of a two-bank synchronous graphics DRAM.
// Assumes pins arrive synchronous to core_clk; the clock enable pin is
// resynchronised because it turns asynchronous in low-power modes.
`timescale 1ns/1ns
module sgd_cmd_interface (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  // Command pins
  input  wire logic                        clk_gate_enable,
  input  wire logic                        chip_select_n,
  input  wire logic                        row_strobe_n,
  input  wire logic                        column_strobe_n,
  input  wire logic                        write_strobe_n,
  input  wire logic                        special_func,
  input  wire logic                        bank_select_in,
  input  wire logic [sgd_pkg::ADDR_W-1:0]  addr_in,
  // Data pins
  input  wire logic [sgd_pkg::LANES-1:0]   byte_mask,
  input  wire logic [sgd_pkg::DATA_W-1:0]  dataIn,
  output logic      [sgd_pkg::DATA_W-1:0]  dataOut,
  output logic      [sgd_pkg::LANES-1:0]   dataOe,
  // Status
  output logic      [sgd_pkg::BANKS-1:0]   bankActive,
  output logic                             powerDown,
  output logic                             selfRefresh,
  output logic      [sgd_pkg::OPC_W-1:0]   modeReg
);

  // State that earlier sections read ahead of its own section
  sgd_pkg::sgd_pwr_t  pwrQ;
  sgd_pkg::sgd_bank_t bankQ [sgd_pkg::BANKS];
  logic               burstQ;

  // ----------------------------------------------------------------
  // Clock enable synchroniser and internal clock gate
  // ----------------------------------------------------------------
  logic cke1Q;
  logic cke2Q;
  logic ckePrevQ;
  logic run;

  // Two-flop synchroniser; the second stage and its one-cycle delay (ckePrevQ) are read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cke1Q    <= 1'b0;
      cke2Q    <= 1'b0;
      ckePrevQ <= 1'b0;
    end else begin
      cke1Q    <= clk_gate_enable;
      cke2Q    <= cke1Q;
      ckePrevQ <= cke2Q;
    end
  end

  // Internal clock runs only when the previous sample was high
  assign run = ckePrevQ && (pwrQ == sgd_pkg::PWR_RUN);

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic                       csnQ, rasnQ, casnQ, wenQ, dsfQ, bsQ;
  logic [sgd_pkg::ADDR_W-1:0] addrQ;
  logic [sgd_pkg::LANES-1:0]  maskQ;
  logic [sgd_pkg::DATA_W-1:0] dinQ;
  logic                       capValidQ;

  // All pins registered on the rising edge only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      csnQ <= 1'b1; rasnQ <= 1'b1; casnQ <= 1'b1; wenQ <= 1'b1;
      dsfQ <= 1'b0; bsQ <= 1'b0; addrQ <= 10'h000; maskQ <= 4'h0;
      dinQ <= 32'h00000000; capValidQ <= 1'b0;
    end else begin
      csnQ  <= chip_select_n;
      rasnQ <= row_strobe_n;
      casnQ <= column_strobe_n;
      wenQ  <= write_strobe_n;
      dsfQ  <= special_func;
      bsQ   <= bank_select_in;
      addrQ <= addr_in;
      maskQ <= byte_mask;
      dinQ  <= dataIn;
      capValidQ <= run;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sgd_pkg::sgd_cmd_t cmd;

  always_comb begin
    if (csnQ || !capValidQ) begin
      cmd = sgd_pkg::CMD_NOP;
    end else begin
      cmd = sgd_pkg::sgd_cmd_t'({rasnQ, casnQ, wenQ});
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  logic [sgd_pkg::OPC_W-1:0]  modeQ;
  logic [sgd_pkg::DATA_W-1:0] maskRegQ;
  logic [sgd_pkg::DATA_W-1:0] colorRegQ;
  logic                       bothIdle;

  assign bothIdle = (bankQ[0] == sgd_pkg::BANK_IDLE) && (bankQ[1] == sgd_pkg::BANK_IDLE);

  // Op-code from bank select and address; special set loads mask or colour instead
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeQ     <= sgd_pkg::MR_RESET;
      maskRegQ  <= 32'hffffffff;
      colorRegQ <= 32'h00000000;
    end else if (cmd == sgd_pkg::CMD_MRS && bothIdle) begin
      if (!dsfQ) begin
        modeQ <= {bsQ, addrQ};
      end else if (addrQ[sgd_pkg::SMR_MASK_BIT]) begin
        maskRegQ <= dinQ;
      end else if (addrQ[sgd_pkg::SMR_COLOR_BIT]) begin
        colorRegQ <= dinQ;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank state, one per bank
  // ----------------------------------------------------------------
  logic [sgd_pkg::ROW_W-1:0] rowQ [sgd_pkg::BANKS];
  logic [1:0]                prCntQ [sgd_pkg::BANKS];
  logic                      autoClose [sgd_pkg::BANKS];
  logic                      burstEnd;
  logic                      burstApQ;
  logic                      burstBankQ;

  genvar gb;
  generate
    for (gb = 0; gb < sgd_pkg::BANKS; gb++) begin : g_bank
      assign autoClose[gb] = burstEnd && burstApQ && (burstBankQ == 1'(gb));
      // Row open, close and self-timed precharge
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          bankQ[gb]  <= sgd_pkg::BANK_IDLE;
          rowQ[gb]   <= 10'h000;
          prCntQ[gb] <= 2'h0;
        end else if (cmd == sgd_pkg::CMD_ACT && bsQ == 1'(gb)
                     && bankQ[gb] == sgd_pkg::BANK_IDLE) begin
          bankQ[gb] <= sgd_pkg::BANK_ACTIVE;
          rowQ[gb]  <= addrQ;
        end else if ((cmd == sgd_pkg::CMD_PRE && (addrQ[sgd_pkg::AP_BIT] || bsQ == 1'(gb)))
                     || autoClose[gb]) begin
          bankQ[gb]  <= sgd_pkg::BANK_PRECH;
          prCntQ[gb] <= 2'(sgd_pkg::TRP_CYC - 1);
        end else if (bankQ[gb] == sgd_pkg::BANK_PRECH && run) begin
          if (prCntQ[gb] == 2'h0) begin
            bankQ[gb] <= sgd_pkg::BANK_IDLE;
          end else begin
            prCntQ[gb] <= prCntQ[gb] - 2'h1;
          end
        end
      end
      // Bank status output
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          bankActive[gb] <= 1'b0;
        end else begin
          bankActive[gb] <= (bankQ[gb] == sgd_pkg::BANK_ACTIVE);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Entry needs both banks idle; exit when the async enable returns high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrQ <= sgd_pkg::PWR_RUN;
    end else begin
      case (pwrQ)
        sgd_pkg::PWR_RUN: begin
          if (!cke2Q && ckePrevQ && bothIdle && !burstQ) begin
            if (!csnQ && cmd == sgd_pkg::CMD_REF) begin
              pwrQ <= sgd_pkg::PWR_SELFREF;
            end else begin
              pwrQ <= sgd_pkg::PWR_DOWN;
            end
          end
        end
        sgd_pkg::PWR_DOWN, sgd_pkg::PWR_SELFREF: begin
          if (cke2Q) begin
            pwrQ <= sgd_pkg::PWR_RUN;
          end
        end
        default: pwrQ <= sgd_pkg::PWR_RUN;
      endcase
    end
  end

  // Power status and mode register outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerDown   <= 1'b0;
      selfRefresh <= 1'b0;
      modeReg     <= sgd_pkg::MR_RESET;
    end else begin
      powerDown   <= (pwrQ == sgd_pkg::PWR_DOWN);
      selfRefresh <= (pwrQ == sgd_pkg::PWR_SELFREF);
      modeReg     <= modeQ;
    end
  end

  // ----------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------
  logic                      burstWrQ;
  logic                      burstBlkQ;
  logic [sgd_pkg::COL_W:0]   beatQ;
  logic [sgd_pkg::COL_W:0]   burstLen;
  logic [sgd_pkg::COL_W-1:0] col;
  logic                      colCmd;
  logic                      isWrite;

  assign colCmd  = (cmd == sgd_pkg::CMD_WRITE || cmd == sgd_pkg::CMD_READ)
                   && bankQ[bsQ] == sgd_pkg::BANK_ACTIVE;
  assign isWrite = (cmd == sgd_pkg::CMD_WRITE);

  // Programmed length in beats
  always_comb begin
    case (modeQ[sgd_pkg::MR_BL_MSB:sgd_pkg::MR_BL_LSB])
      sgd_pkg::BL_1:    burstLen = 9'h001;
      sgd_pkg::BL_2:    burstLen = 9'h002;
      sgd_pkg::BL_4:    burstLen = 9'h004;
      sgd_pkg::BL_8:    burstLen = 9'h008;
      sgd_pkg::BL_PAGE: burstLen = 9'h100;
      default:          burstLen = 9'h001;
    endcase
  end

  // Single writes when write-burst bit set; block write is one beat
  assign burstEnd = burstQ && run && (beatQ + 9'h001 >= ((burstWrQ &&
                    (modeQ[sgd_pkg::MR_WB_BIT] || burstBlkQ)) ? 9'h001 : burstLen));

  // Burst start, stop and beat count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      burstQ <= 1'b0; burstWrQ <= 1'b0; burstBlkQ <= 1'b0;
      burstApQ <= 1'b0; burstBankQ <= 1'b0; beatQ <= 9'h000;
    end else if (colCmd) begin
      burstQ     <= 1'b1;
      burstWrQ   <= isWrite;
      burstBlkQ  <= isWrite && dsfQ;
      burstApQ   <= addrQ[sgd_pkg::AP_BIT];
      burstBankQ <= bsQ;
      beatQ      <= 9'h000;
    end else if (cmd == sgd_pkg::CMD_STOP || burstEnd) begin
      burstQ <= 1'b0;
    end else if (burstQ && run) begin
      beatQ <= beatQ + 9'h001;
    end
  end

  sgd_burst_addr u_burst (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (colCmd),
    .step       (burstQ && run),
    .startCol   (addrQ[sgd_pkg::COL_W-1:0]),
    .interleave (modeQ[sgd_pkg::MR_BT_BIT]),
    .col        (col)
  );

  // ----------------------------------------------------------------
  // Storage and data path
  // ----------------------------------------------------------------
  logic [sgd_pkg::DATA_W-1:0] memQ [2**(1+sgd_pkg::ROW_W+sgd_pkg::COL_W)];
  logic [sgd_pkg::ROW_W+sgd_pkg::COL_W:0] memIdx;
  logic [sgd_pkg::DATA_W-1:0] bitEn;
  logic [sgd_pkg::DATA_W-1:0] rdPipeQ [3];
  logic [2:0]                 rdVldQ;
  logic [sgd_pkg::LANES-1:0]  mask1Q;

  assign memIdx = {burstBankQ, rowQ[burstBankQ], col};

  // Lane masks, then write-per-bit mask when masked write is enabled
  always_comb begin
    for (int l = 0; l < sgd_pkg::LANES; l++) begin
      bitEn[l*8 +: 8] = maskQ[l] ? 8'h00 : 8'hff;
    end
    if (dsfQ || burstBlkQ) begin
      bitEn = bitEn & maskRegQ;
    end
  end

  // Writes: normal beat, or block write of colour to the columns of an eight-column block picked by data bits 7:0
  always_ff @(posedge core_clk) begin
    if (burstQ && burstWrQ && run) begin
      if (burstBlkQ) begin
        for (int c = 0; c < 8; c++) begin
          if (dinQ[c]) begin
            memQ[{memIdx[sgd_pkg::ROW_W+sgd_pkg::COL_W:3], 3'(c)}] <=
              (memQ[{memIdx[sgd_pkg::ROW_W+sgd_pkg::COL_W:3], 3'(c)}] & ~bitEn)
              | (colorRegQ & bitEn);
          end
        end
      end else begin
        memQ[memIdx] <= (memQ[memIdx] & ~bitEn) | (dinQ & bitEn);
      end
    end
  end

  // Read pipeline and delayed mask, frozen while suspended
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPipeQ[0] <= 32'h00000000; rdPipeQ[1] <= 32'h00000000;
      rdPipeQ[2] <= 32'h00000000; rdVldQ <= 3'h0;
      mask1Q <= 4'h0;
    end else if (run) begin
      rdPipeQ[0] <= memQ[memIdx];
      rdPipeQ[1] <= rdPipeQ[0];
      rdPipeQ[2] <= rdPipeQ[1];
      rdVldQ     <= {rdVldQ[1:0], burstQ && !burstWrQ};
      mask1Q     <= maskQ;
    end
  end

  // Output registers pick the stage for the programmed latency
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut <= 32'h00000000;
      dataOe  <= 4'h0;
    end else if (run) begin
      case (modeQ[sgd_pkg::MR_CL_MSB:sgd_pkg::MR_CL_LSB])
        3'h1: begin
          dataOut <= rdPipeQ[0];
          dataOe  <= {4{rdVldQ[0]}} & ~mask1Q;
        end
        3'h3: begin
          dataOut <= rdPipeQ[2];
          dataOe  <= {4{rdVldQ[2]}} & ~mask1Q;
        end
        default: begin
          dataOut <= rdPipeQ[1];
          dataOe  <= {4{rdVldQ[1]}} & ~mask1Q;
        end
      endcase
    end else begin
      dataOe <= dataOe;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cs_masks: assert property (@(posedge core_clk) disable iff (!arst_n)
    csnQ |-> cmd == sgd_pkg::CMD_NOP) else $error("command decoded with chip select high");
  a_act_opens: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cmd == sgd_pkg::CMD_ACT && bankQ[0] == sgd_pkg::BANK_IDLE && !bsQ)
    |=> bankQ[0] == sgd_pkg::BANK_ACTIVE && rowQ[0] == $past(addrQ))
    else $error("row open did not activate bank");
  a_pre_all: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cmd == sgd_pkg::CMD_PRE && addrQ[sgd_pkg::AP_BIT])
    |=> bankQ[0] == sgd_pkg::BANK_PRECH && bankQ[1] == sgd_pkg::BANK_PRECH)
    else $error("close all missed a bank");
  a_mode_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cmd == sgd_pkg::CMD_MRS && bothIdle && !dsfQ) |=> modeQ == $past({bsQ, addrQ}))
    else $error("mode register not loaded");
  a_freeze_burst: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!run && !colCmd) |=> $stable(beatQ)) else $error("burst moved while suspended");
  a_pd_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(pwrQ != sgd_pkg::PWR_RUN) |-> $past(bothIdle)) else $error("low power with bank open");
  a_stop_burst: assert property (@(posedge core_clk) disable iff (!arst_n)
    (cmd == sgd_pkg::CMD_STOP && !colCmd) |=> !burstQ) else $error("burst stop ignored");
  a_mask_lat: assert property (@(posedge core_clk) disable iff (!arst_n)
    (run && maskQ[0]) ##1 run |=> !dataOe[0]) else $error("read mask latency wrong");

endmodule

// ---- sgd_ctrl_model.sv ----
// Controller model: drives the command, bank and address pins of the memory.
// Assumes the bench calls issue() and that pins change at the falling edge.
`timescale 1ns/1ns
module sgd_ctrl_model (
  // Clock
  input  wire logic                   core_clk,
  // Command pins
  output logic                        chip_select_n,
  output logic                        row_strobe_n,
  output logic                        column_strobe_n,
  output logic                        write_strobe_n,
  output logic                        bank_select_in,
  output logic [sgd_pkg::ADDR_W-1:0]  addr_in
);
  // ----------------------------------------------------------------
  // Command launch
  // ----------------------------------------------------------------
  logic [14:0] cmdQ;
  logic        pend = 1'b0;
  logic [9:0]  pat  = 10'h000;

  // Deselected at time zero
  initial {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = 4'hf;

  // One cycle of command, otherwise deselected with lines scrambled so
  // that nothing can lean on a stale value
  always @(negedge core_clk) begin
    if (pend) begin
      {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
       bank_select_in, addr_in} <= cmdQ;
      pend <= 1'b0;
    end else begin
      chip_select_n <= 1'b1;
      {row_strobe_n, column_strobe_n, write_strobe_n, bank_select_in} <= pat[3:0];
      addr_in <= ~pat;
      pat     <= pat + 10'h001;
    end
  end

  // Queue a command; returns at the edge that captures it
  task automatic issue(input logic [3:0] c, input logic b, input logic [9:0] a);
    @(posedge core_clk);
    cmdQ = {c, b, a};
    pend = 1'b1;
    @(posedge core_clk);
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the graphics DRAM command interface.
// Assumes the controller model drives the command pins at the falling edge.
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Signals and table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  cmd;
    logic        bs;
    logic [9:0]  addr;
    logic [1:0]  bank;
    logic [10:0] mode;
  } sgd_row_t;

  logic        core_clk, arst_n, clk_gate_enable, special_func;
  logic        chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n;
  logic        bank_select_in, powerDown, selfRefresh;
  logic [9:0]  addr_in;
  logic [3:0]  byte_mask, dataOe;
  logic [31:0] dataIn, dataOut;
  logic [1:0]  bankActive;
  logic [10:0] modeReg;
  int          errors = 0;
  int          checks = 0;
  int          n;

  // Command code is {cs, row, column, write}, all active low
  sgd_row_t rows [8] = '{
    '{4'h3, 1'b0, 10'h155, 2'h1, 11'h021},
    '{4'hb, 1'b1, 10'h0aa, 2'h1, 11'h021},
    '{4'h7, 1'b1, 10'h000, 2'h1, 11'h021},
    '{4'h3, 1'b1, 10'h3ff, 2'h3, 11'h021},
    '{4'h2, 1'b0, 10'h000, 2'h2, 11'h021},
    '{4'h3, 1'b0, 10'h001, 2'h3, 11'h021},
    '{4'h2, 1'b0, 10'h200, 2'h0, 11'h021},
    '{4'h0, 1'b1, 10'h032, 2'h0, 11'h432}};

  sgd_cmd_interface i_sgd_cmd_interface (.core_clk(core_clk), .arst_n(arst_n),
    .clk_gate_enable(clk_gate_enable), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .special_func(special_func),
    .bank_select_in(bank_select_in), .addr_in(addr_in), .byte_mask(byte_mask),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .bankActive(bankActive),
    .powerDown(powerDown), .selfRefresh(selfRefresh), .modeReg(modeReg));

  sgd_ctrl_model i_sgd_ctrl_model (.core_clk(core_clk), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select_in(bank_select_in), .addr_in(addr_in));

  // ----------------------------------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------------------------------
  always #25 core_clk = ~core_clk;

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Count beats with all lanes driven and check their data
  task automatic readBeats(input logic [31:0] exp, output int cnt);
    cnt = 0;
    repeat (16) begin
      @(negedge core_clk);
      if (dataOe === 4'hf) begin
        cnt++;
        chk(dataOut, exp);
      end
    end
  endtask

  // Wait a bounded time for the bank levels
  task automatic waitBank(input logic [1:0] exp);
    int k;
    k = 0;
    while (bankActive !== exp && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    chk(32'(bankActive), 32'(exp));
  endtask

  // Verdict and end of run
  task automatic results;
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(3000 * 50);
    errors++;
    results;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    clk_gate_enable = 1'b1;
    special_func = 1'b0;
    byte_mask = 4'h0;
    dataIn = 32'h0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    chk(32'(modeReg), 32'h021);
    chk(32'(bankActive), 32'h0);
    repeat (5) @(negedge core_clk);
    // Table of bank, chip select and mode cases
    for (int i = 0; i < 8; i++) begin
      i_sgd_ctrl_model.issue(rows[i].cmd, rows[i].bs, rows[i].addr);
      repeat (8) @(negedge core_clk);
      chk(32'(bankActive), 32'(rows[i].bank));
      chk(32'(modeReg), 32'(rows[i].mode));
    end
    // Four-beat read with lane zero masked
    byte_mask = 4'h1;
    i_sgd_ctrl_model.issue(4'h3, 1'b0, 10'h000);
    repeat (4) @(negedge core_clk);
    i_sgd_ctrl_model.issue(4'h5, 1'b0, 10'h004);
    n = 0;
    repeat (16) begin
      @(negedge core_clk);
      if (dataOe !== 4'h0) begin
        n++;
        chk(32'(dataOe), 32'he);
      end
    end
    chk(32'(n), 32'h4);
    chk(32'(bankActive), 32'h1);
    // Read with auto precharge closes the bank by itself
    byte_mask = 4'h0;
    i_sgd_ctrl_model.issue(4'h5, 1'b0, 10'h200);
    waitBank(2'h0);
    // Power-down entry and exit while idle
    clk_gate_enable = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(32'(powerDown), 32'h1);
    clk_gate_enable = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(32'(powerDown), 32'h0);
    // Refresh strobes with the clock enable dropping enter self-refresh
    clk_gate_enable = 1'b0;
    i_sgd_ctrl_model.issue(4'h1, 1'b0, 10'h000);
    repeat (8) @(negedge core_clk);
    chk(32'(selfRefresh), 32'h1);
    chk(32'(powerDown), 32'h0);
    clk_gate_enable = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(32'(selfRefresh), 32'h0);
    i_sgd_ctrl_model.issue(4'h3, 1'b1, 10'h000);
    waitBank(2'h2);
    // Burst write to the open bank, read back in full, then a stopped read
    dataIn = 32'h5a5ac3c3;
    i_sgd_ctrl_model.issue(4'h4, 1'b1, 10'h010);
    repeat (8) @(negedge core_clk);
    i_sgd_ctrl_model.issue(4'h5, 1'b1, 10'h010);
    readBeats(32'h5a5ac3c3, n);
    chk(32'(n), 32'h4);
    i_sgd_ctrl_model.issue(4'h5, 1'b1, 10'h010);
    i_sgd_ctrl_model.issue(4'h6, 1'b1, 10'h000);
    readBeats(32'h5a5ac3c3, n);
    chk(32'(n), 32'h2);
    // Reset in mid-run clears the open bank and returns the mode register to its reset value
    arst_n = 1'b0;
    @(negedge core_clk);
    chk(32'(bankActive), 32'h0);
    chk(32'(modeReg), 32'h021);
    arst_n = 1'b1;
    results;
  end
endmodule
